// [rtl/local_memory_port_strobes.sv]
// Request FIFO and strobe sequencer for the local code/data memory port
`timescale 1ns/1ps

// ****************************************
// Request FIFO
// ****************************************
module lmp_req_fifo #(
  parameter int WIDTH = 50,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire [PW:0]       next_count = count + (PW+1)'(push) - (PW+1)'(pop);

  assign out_data  = store[rd_ptr];
  assign out_valid = (count != '0);

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_C) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_C) ? '0 : rd_ptr + PW'(1);
      end
      count    <= next_count;
      in_ready <= (next_count != DEPTH_C);
    end
  end
endmodule : lmp_req_fifo

// Notes on behaviour
// - Split bit low: space select line shows instruction or data word.
// - Split bit low: code memory enable held steady through an access sequence.
// - Output enable returns high at every access cycle edge during reads.
// - Write strobe returns high at every access cycle edge during writes.
// - Split bit high: space select is data chip enable, memory enable is code.
// - Split mode: both chip enables return high after every access cycle.
// - Split mode: data and code chip enables never low together.
// - Each access cycle runs as four quarter phases, first to fourth.
// - Back-to-back writes in consecutive cycles, code and data alike.
// - While reset is held both data buses float.
// - On reset release the sequencer restarts at address zero.
module local_memory_port_strobes (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    split_enable_config_bit,
  input  wire lmp_pkg::mem_req_s       req,
  input  wire logic                    req_valid,
  output logic                         req_ready,
  output logic [lmp_pkg::ADDR_W-1:0]   local_memory_address_bus,
  output logic [lmp_pkg::DATA_W-1:0]   local_memory_data_out,
  output logic                         local_memory_data_oe,
  input  wire logic [lmp_pkg::DATA_W-1:0] local_memory_data_in,
  output logic                         memory_output_enable_n,
  output logic                         memory_write_strobe_n,
  output logic                         space_select_line,
  output logic                         code_memory_enable_n,
  output logic [lmp_pkg::DATA_W-1:0]   host_data_out,
  output logic                         host_data_oe,
  output logic [lmp_pkg::ADDR_W-1:0]   exec_address
);
  import lmp_pkg::*;

  // ****************************************
  // Request buffering
  // ****************************************
  mem_req_s   head;
  logic       head_valid;
  logic       head_ready;

  lmp_req_fifo #(
    .WIDTH ($bits(mem_req_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   (req),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .out_data  (head),
    .out_valid (head_valid),
    .out_ready (head_ready)
  );

  // ****************************************
  // Quarter phase divider
  // ****************************************
  logic [7:0] qcnt;
  wire        quarter_tick = (qcnt == QUARTER_LAST);

  always_ff @(posedge clk) begin
    if (srst) begin
      qcnt <= '0;
    end else begin
      qcnt <= quarter_tick ? '0 : qcnt + 8'h01;
    end
  end

  // ****************************************
  // Access sequencer
  // ****************************************
  seq_state_e state;
  logic [1:0] phase;
  access_s    cur;

  wire        at_boundary = (state == ST_IDLE) || (phase == PHASE_Q4);
  assign head_ready       = quarter_tick && at_boundary;
  wire        take        = head_ready && head_valid;

  wire access_s loaded = '{split: split_enable_config_bit, write: head.write,
                           code_space: head.code_space, addr: head.addr, data: head.data};

  // Back-to-back requests start at the next Q1 with no idle gap
  wire seq_state_e next_state =
    take ? ST_ACTIVE : ((quarter_tick && at_boundary) ? ST_IDLE : state);
  wire [1:0]  next_phase =
    take ? PHASE_Q1 : ((quarter_tick && state == ST_ACTIVE) ? phase + 2'h1 : phase);
  wire access_s next_cur = take ? loaded : cur;

  wire next_active = (next_state == ST_ACTIVE);
  // Strobes are low only in Q2 and Q3, so they rise at each cycle edge
  wire next_mid    = next_active && (next_phase == PHASE_Q2 || next_phase == PHASE_Q3);
  wire next_rd     = next_mid && !next_cur.write;
  wire next_wr     = next_mid && next_cur.write;
  wire next_split  = next_cur.split;

  // Split mode enables come from one space bit, so only one can be low
  wire next_dsel_n = !(next_mid && !next_cur.code_space);
  wire next_csel_n = !(next_mid && next_cur.code_space);

  wire next_space  = next_split ? next_dsel_n
                                : (next_active ? !next_cur.code_space : space_select_line);
  wire next_mce_n  = next_split ? next_csel_n : !next_active;

  // Data bus driven Q2..Q4 of writes only
  wire next_data_oe = next_active && next_cur.write && (next_phase != PHASE_Q1);

  wire capture     = quarter_tick && (state == ST_ACTIVE) && !cur.write && (phase == PHASE_Q3);

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      phase <= PHASE_Q1;
      cur   <= '0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cur   <= next_cur;
    end
  end

  // ****************************************
  // Pin registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      local_memory_address_bus <= '0;
      local_memory_data_out    <= '0;
      local_memory_data_oe     <= 1'b0;
      memory_output_enable_n   <= STROBE_OFF;
      memory_write_strobe_n    <= STROBE_OFF;
      space_select_line        <= SPACE_DATA;
      code_memory_enable_n     <= STROBE_OFF;
    end else begin
      local_memory_address_bus <= next_cur.addr;
      local_memory_data_out    <= next_cur.data;
      local_memory_data_oe     <= next_data_oe;
      memory_output_enable_n   <= !next_rd;
      memory_write_strobe_n    <= !next_wr;
      space_select_line        <= next_space;
      code_memory_enable_n     <= next_mce_n;
    end
  end

  // ****************************************
  // Read return and instruction address
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      host_data_out <= '0;
      host_data_oe  <= 1'b0;
      exec_address  <= EXEC_RESET_ADDR;
    end else begin
      host_data_oe <= capture;
      if (capture) begin
        host_data_out <= local_memory_data_in;
      end
      if (capture && cur.code_space) begin
        exec_address <= cur.addr + EXEC_STEP;
      end
    end
  end
endmodule : local_memory_port_strobes

// [pkg/lmp_pkg.sv]
// Constants, types and carriers for the local memory strobe port
package lmp_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 32;
  localparam int          FIFO_DEPTH      = 4;
  localparam logic [15:0] EXEC_RESET_ADDR = 16'h0000;
  localparam logic [15:0] EXEC_STEP       = 16'h0001;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          QUARTER_NS      = 10;
  localparam int          QUARTER_CYCLES  = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  QUARTER_LAST    = 8'(QUARTER_CYCLES - 1);
  localparam logic [1:0]  PHASE_Q1        = 2'h0;
  localparam logic [1:0]  PHASE_Q2        = 2'h1;
  localparam logic [1:0]  PHASE_Q3        = 2'h2;
  localparam logic [1:0]  PHASE_Q4        = 2'h3;
  localparam logic        STROBE_OFF      = 1'b1;
  localparam logic        SPACE_DATA      = 1'b1;

  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_ACTIVE = 1'b1
  } seq_state_e;

  typedef struct packed {
    logic              write;
    logic              code_space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_req_s;

  typedef struct packed {
    logic              split;
    logic              write;
    logic              code_space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } access_s;
endpackage : lmp_pkg

// [bench/lmp_monitor.sv]
// Concurrent checks on the strobe port pins
`timescale 1ns/1ps
module lmp_monitor (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        split_enable_config_bit,
  input wire logic        local_memory_data_oe,
  input wire logic        memory_output_enable_n,
  input wire logic        memory_write_strobe_n,
  input wire logic        space_select_line,
  input wire logic        code_memory_enable_n,
  input wire logic        host_data_oe,
  input wire logic [15:0] exec_address
);
  wire s    = split_enable_config_bit;
  wire oe_n = memory_output_enable_n;
  wire wr_n = memory_write_strobe_n;
  wire ssl  = space_select_line;
  wire ce_n = code_memory_enable_n;
  wire d_oe = local_memory_data_oe;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ********
  // Strobes
  // ********
  chk_read_pulse: assert property ($fell(oe_n) |=> !oe_n ##1 oe_n) else $error("read pulse");
  chk_write_pulse: assert property ($fell(wr_n) |=> !wr_n ##1 wr_n) else $error("write pulse");
  chk_read_return: assert property ($rose(oe_n) |-> host_data_oe) else $error("read return");
  chk_code_steady: assert property (!s && !ssl && $fell(ce_n) |-> !ce_n [*4]) else $error("enable steady");
  chk_split_code: assert property (s && $fell(ce_n) |=> !ce_n ##1 ce_n) else $error("code pulse");
  chk_split_data: assert property (s && $fell(ssl) |=> !ssl ##1 ssl) else $error("data pulse");
  chk_split_excl: assert property (s && !ce_n |-> ssl) else $error("both enables");
  chk_no_contend: assert property (!oe_n |-> !d_oe) else $error("contention");
  chk_write_drive: assert property ($fell(wr_n) |-> d_oe [*3] ##1 !d_oe) else $error("data drive");
  chk_reset_float: assert property (disable iff (1'b0)
    srst |=> !d_oe && !host_data_oe && exec_address == 16'h0) else $error("reset state");
endmodule : lmp_monitor

bind local_memory_port_strobes lmp_monitor u_lmp_monitor (.clk, .srst, .split_enable_config_bit,
  .local_memory_data_oe, .memory_output_enable_n, .memory_write_strobe_n, .space_select_line,
  .code_memory_enable_n, .host_data_oe, .exec_address);

// [bench/sram_model.sv]
// Static code and data memory behind the strobe port
`timescale 1ns/1ps
module sram_model (
  input wire logic        clk,
  input wire logic        split,
  input wire logic        ssl,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        wr_n,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  output logic     [31:0] rdata
);
  logic [31:0] mem [32];
  logic [31:0] last = 32'h0;
  wire code = split ? !ce_n : !ssl;
  wire [4:0] idx = {code, addr[3:0]};
  // Released bus shows the inverse of the last word
  assign rdata = !oe_n ? mem[idx] : ~last;
  always @(posedge clk) begin
    if (!wr_n) mem[idx] <= wdata;
    if (!oe_n) last <= mem[idx];
  end
endmodule : sram_model

// [bench/local_memory_port_strobes_tb_top.sv]
// Self-checking bench for the local memory strobe port
`timescale 1ns/1ps
module local_memory_port_strobes_tb_top;
  import lmp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic split = 1'b0;
  mem_req_s req = '0;
  logic req_valid = 1'b0;
  logic req_ready, data_oe, oe_n, wr_n, ssl, ce_n, host_oe, wr_q;
  logic [15:0] addr, exec_address;
  logic [31:0] wdata, rdata, host_data;
  int bad_count = 0;
  int n_compared = 0;
  int pulses = 0;
  int full_seen = 0;
  logic [50:0] rows [8];
  always #5 clk = ~clk;
  local_memory_port_strobes u_local_memory_port_strobes (.clk(clk), .srst(srst), .split_enable_config_bit(split),
    .req(req), .req_valid(req_valid), .req_ready(req_ready), .local_memory_address_bus(addr),
    .local_memory_data_out(wdata), .local_memory_data_oe(data_oe), .local_memory_data_in(rdata),
    .memory_output_enable_n(oe_n), .memory_write_strobe_n(wr_n), .space_select_line(ssl),
    .code_memory_enable_n(ce_n), .host_data_out(host_data), .host_data_oe(host_oe), .exec_address(exec_address));
  sram_model u_sram_model (.clk(clk), .split(split), .ssl(ssl), .ce_n(ce_n), .oe_n(oe_n), .wr_n(wr_n),
    .addr(addr), .wdata(wdata), .rdata(rdata));
  always @(posedge clk) begin
    if (wr_q === 1'b1 && wr_n === 1'b0) pulses++;
    if (req_ready === 1'b0) full_seen++;
    wr_q <= wr_n;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic send(input logic s, input mem_req_s r);
    @(negedge clk);
    split = s;
    req = r;
    req_valid = 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
  endtask : send
  task automatic await(input logic rd);
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(rd ? host_oe === 1'b1 : (oe_n === 1'b0 || wr_n === 1'b0)) && n < 20);
    chk("handshake wait", 32'h1, {n < 20});
  endtask : await
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Tests take about two hundred cycles
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    rows = '{{3'b011, 16'h1, 32'h11110001}, {3'b010, 16'h2, 32'h22220002}, {3'b111, 16'h3, 32'h33330003},
             {3'b110, 16'h4, 32'h44440004}, {3'b000, 16'h2, 32'h22220002}, {3'b101, 16'h1, 32'h11110001},
             {3'b001, 16'h3, 32'h33330003}, {3'b100, 16'h4, 32'h44440004}};
    repeat (20) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      send(rows[i][50], rows[i][49:0]);
      @(negedge clk) req_valid = 1'b0;
      await(1'b0);
      chk("space select", {rows[i][50] ~^ rows[i][48]}, ssl);
      if (rows[i][50] | rows[i][48]) chk("code enable", {~rows[i][48]}, ce_n);
      if (!rows[i][49]) await(1'b1);
      if (!rows[i][49]) chk("read data", rows[i][31:0], host_data);
      repeat (4) @(negedge clk);
      if (!rows[i][49] && rows[i][48]) chk("exec address", rows[i][47:32] + EXEC_STEP, exec_address);
      $display("row %0d done", i);
    end
    for (int s = 0; s < 2; s++) begin
      pulses = 0;
      full_seen = 0;
      for (int k = 0; k < 7; k++) send(s[0], {2'b11, 16'(k), 32'(k)});
      @(negedge clk) req_valid = 1'b0;
      repeat (40) @(negedge clk);
      chk("write pulses", 32'h7, pulses);
      chk("fifo refused", 32'h1, {full_seen > 0});
      $display("burst %0d done", s);
    end
    send(1'b0, {2'b10, 16'h5, 32'h55550005});
    @(negedge clk) req_valid = 1'b0;
    await(1'b0);
    srst = 1'b1;
    @(negedge clk);
    chk("memory data drive", 32'h0, data_oe);
    chk("host data drive", 32'h0, host_oe);
    chk("write strobe", 32'h1, wr_n);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk("exec address", 32'h0, exec_address);
    $display("reset test done");
    report_and_stop;
  end
endmodule : local_memory_port_strobes_tb_top
